// file: design/wrt_pkg.sv
// Purpose: shared constants for the watchdog reset timer
// Assumes: clock is the quad bus clock
// Notes: register offsets, field positions and cycle counts
`default_nettype none
package wrt_pkg;
    // ****************************************
    // bus and register map
    // ****************************************
    localparam int            ADDR_W        = 16;
    localparam int            DATA_W        = 8;
    localparam logic [15:0]   SERVICE_ADDR  = 16'hffff;
    localparam logic [15:0]   OPTIONS_ADDR  = 16'h001f;
    localparam int            DISABLE_BIT   = 0;
    localparam int            PERIOD_BIT    = 7;
    localparam logic [7:0]    OPTIONS_RESET = 8'h00;
    localparam logic [7:0]    UNMAPPED_DATA = 8'h00;
    // ****************************************
    // counter shape and timing
    // ****************************************
    localparam int            PRE_W         = 12;
    localparam int            CNT_W         = 6;
    localparam int            TOT_W         = PRE_W + CNT_W;
    localparam logic [11:0]   SERVICE_KEEP  = 12'h00f;
    localparam int            SHORT_CYCLES  = 8176;
    localparam int            LONG_CYCLES   = 262128;
    localparam int            PIN_LOW_CYCLES = 32;
    localparam int            POR_CYCLES    = 4096;
    localparam int            PIN_W         = 6;
    localparam int            POR_W         = 13;
    // ****************************************
    // reset sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_ALARM = 2'b10
    } wrt_state_type;
endpackage
`default_nettype wire

// file: design/wrt_watchdog.sv
// Purpose: watchdog timer that requests a system reset unless serviced
// Assumes: i_clk_sys is the quad bus clock; inputs synchronous to it
// Notes: one 8-bit register port, read data one cycle after the strobe
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
// What this block does
// - six-bit counter clocked by carry out of twelve-bit prescaler
// - unserviced counter overflows into reset after 8176 or 262128 cycles
// - period select one gives short timeout, zero gives long timeout
// - any write to service register clears counter and prescaler stages 12-5
// - reading service location returns reset vector low byte, counters untouched
// - watchdog reset drives pin low 32 cycles if enabled, sets cause flag
// - stop instruction clears the prescaler
// - prescaler cleared 4096 cycles after power-up
// - any internal reset clears prescaler and watchdog counter
// - disable bit set means no watchdog reset at all
// - no interrupt request, only a reset request output
// - watchdog held off in monitor mode entered with test voltage
// - watchdog keeps counting in wait mode
// - stop mode freezes watchdog clock and clears prescaler
// - break in monitor mode with break disable bit stops watchdog
// - options register takes one write per reset, reads always allowed
module wrt_watchdog
    import wrt_pkg::*;
#(
    parameter logic [7:0] VECTOR_LOW = 8'h00
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rd_data,
    input  wire logic              i_int_rst,
    input  wire logic              i_stop_exec,
    input  wire logic              i_stop_mode,
    input  wire logic              i_wait_mode,
    input  wire logic              i_monitor_mode,
    input  wire logic              i_test_voltage,
    input  wire logic              i_break_active,
    input  wire logic              i_break_watchdog_disable,
    input  wire logic              i_reset_pin_enable,
    input  wire logic              i_cause_clear,
    output logic                   o_sys_reset_req,
    output logic                   o_rst_pin_out,
    output logic                   o_rst_pin_oe,
    output logic                   o_cause_flag
);
    // ****************************************
    // state
    // ****************************************
    logic [PRE_W-1:0]  pre;
    logic [PRE_W-1:0]  next_pre;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [7:0]        options;
    logic              opt_written;
    logic [PIN_W-1:0]  pin_cnt;
    logic [PIN_W-1:0]  next_pin_cnt;
    logic [POR_W-1:0]  por_cnt;
    logic              por_done;
    wrt_state_type     state;
    wrt_state_type     next_state;
    logic              cause;

    // ****************************************
    // decode
    // ****************************************
    wire logic             svc_hit;
    wire logic             opt_hit;
    wire logic             svc_write;
    wire logic             opt_write;
    wire logic [7:0]       rd_mux;
    wire logic             stop_gate;
    wire logic             monitor_off;
    wire logic             break_off;
    wire logic             wd_enabled;
    wire logic             carry;
    wire logic             por_clear;
    wire logic [TOT_W-1:0] total;
    wire logic [TOT_W-1:0] limit;
    wire logic             fire;
    wire logic             alarm;
    wire logic             pin_last;

    assign svc_hit   = i_addr == SERVICE_ADDR;
    assign opt_hit   = i_addr == OPTIONS_ADDR;
    assign svc_write = i_wr && svc_hit;
    assign opt_write = i_wr && opt_hit && !opt_written;
    assign rd_mux    = svc_hit ? VECTOR_LOW :
                       opt_hit ? options : UNMAPPED_DATA;

    // wait mode does not appear here: counting goes on
    assign stop_gate   = i_stop_mode;
    assign monitor_off = i_monitor_mode && i_test_voltage;
    assign break_off   = i_break_active && i_monitor_mode
                         && i_break_watchdog_disable;
    assign wd_enabled  = !options[DISABLE_BIT] && !monitor_off
                         && !break_off;

    assign carry     = pre == {PRE_W{1'b1}};
    assign por_clear = !por_done && por_cnt == POR_W'(POR_CYCLES - 1);
    assign total     = {cnt, pre};
    assign limit     = options[PERIOD_BIT] ? TOT_W'(SHORT_CYCLES - 1)
                                           : TOT_W'(LONG_CYCLES - 1);
    assign alarm     = state == ST_ALARM;
    assign fire      = !alarm && wd_enabled && !stop_gate
                       && !i_int_rst && !svc_write
                       && total == limit;
    assign pin_last  = pin_cnt == '0;

    // ****************************************
    // prescaler and watchdog counter
    // ****************************************
    always_comb begin
        if (i_int_rst || alarm) begin
            next_pre = '0;
        end else if (i_stop_exec || por_clear) begin
            next_pre = '0;
        end else if (stop_gate) begin
            next_pre = '0;
        end else if (svc_write) begin
            next_pre = pre & SERVICE_KEEP;
        end else begin
            next_pre = pre + 1'b1;
        end
    end

    always_comb begin
        if (i_int_rst || alarm) begin
            next_cnt = '0;
        end else if (!wd_enabled) begin
            next_cnt = '0;
        end else if (svc_write) begin
            next_cnt = '0;
        end else if (stop_gate) begin
            next_cnt = cnt;
        end else if (carry) begin
            next_cnt = cnt + 1'b1;
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pre <= '0;
            cnt <= '0;
        end else begin
            pre <= next_pre;
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // power-up prescaler clear
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            por_cnt  <= '0;
            por_done <= 1'b0;
        end else if (por_clear) begin
            por_done <= 1'b1;
        end else if (!por_done) begin
            por_cnt  <= por_cnt + 1'b1;
        end
    end

    // ****************************************
    // options register
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            options     <= OPTIONS_RESET;
            opt_written <= 1'b0;
        end else if (i_int_rst) begin
            options     <= OPTIONS_RESET;
            opt_written <= 1'b0;
        end else if (opt_write) begin
            options     <= i_wr_data;
            opt_written <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= '0;
        end else if (i_rd) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= '0;
        end
    end

    // ****************************************
    // reset sequencer
    // ****************************************
    always_comb begin
        next_state   = state;
        next_pin_cnt = pin_cnt;
        case (state)
            ST_RUN: begin
                if (fire) begin
                    next_state   = ST_ALARM;
                    next_pin_cnt = PIN_W'(PIN_LOW_CYCLES - 1);
                end
            end
            ST_ALARM: begin
                if (pin_last) begin
                    next_state = ST_RUN;
                end else begin
                    next_pin_cnt = pin_cnt - 1'b1;
                end
            end
            default: begin
                next_state   = ST_RUN;
                next_pin_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state   <= ST_RUN;
            pin_cnt <= '0;
        end else begin
            state   <= next_state;
            pin_cnt <= next_pin_cnt;
        end
    end

    // cause flag: a new timeout wins over a clear
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cause <= 1'b0;
        end else if (fire) begin
            cause <= 1'b1;
        end else if (i_cause_clear) begin
            cause <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_sys_reset_req = alarm;
    assign o_rst_pin_out   = 1'b0;
    assign o_rst_pin_oe    = alarm && i_reset_pin_enable;
    assign o_cause_flag    = cause;

    // ****************************************
    // checks
    // ****************************************
    sequence seq_pulse_start;
        $rose(o_sys_reset_req);
    endsequence

    sequence seq_pulse_body;
        o_sys_reset_req [*8] ##1 o_sys_reset_req [*8]
        ##1 o_sys_reset_req [*8] ##1 o_sys_reset_req [*8];
    endsequence

    property p_pulse_len;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        seq_pulse_start |-> seq_pulse_body ##1 !o_sys_reset_req;
    endproperty

    AST_PULSE_32: assert property (p_pulse_len)
        else $error("reset pulse is not 32 cycles");

    AST_PIN_FOLLOWS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_rst_pin_oe == (o_sys_reset_req && i_reset_pin_enable))
        else $error("pin drive does not match reset pulse");

    AST_CAUSE_SET: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        seq_pulse_start |-> o_cause_flag)
        else $error("cause flag missing on watchdog reset");

    AST_SERVICE_CLEARS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        svc_write |=> cnt == '0 && pre[PRE_W-1:4] == '0)
        else $error("service write did not clear counters");

    AST_READ_VECTOR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_rd && svc_hit |=> o_rd_data == VECTOR_LOW)
        else $error("service read returned wrong data");

    AST_READ_NO_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_rd && svc_hit && !i_wr && wd_enabled && !stop_gate && !i_int_rst
        && !alarm && !carry |=> cnt == $past(cnt))
        else $error("service read disturbed the counter");

    AST_TIMEOUT_LIMIT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        seq_pulse_start |-> $past(total) == $past(limit))
        else $error("reset fired at the wrong count");

    AST_DISABLED_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !wd_enabled |=> cnt == '0 && !$rose(o_sys_reset_req))
        else $error("disabled watchdog kept counting");

    AST_STOP_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_stop_exec |=> pre == '0)
        else $error("stop did not clear prescaler");

    AST_STOP_FREEZE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        stop_gate && wd_enabled && !i_int_rst && !svc_write && !alarm
        |=> $stable(cnt))
        else $error("watchdog counted in stop mode");

    AST_INT_RESET: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_int_rst |=> pre == '0 && cnt == '0)
        else $error("internal reset left counters running");

    AST_OPTIONS_ONCE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        opt_written && !i_int_rst |=> $stable(options))
        else $error("options register took a second write");

    AST_POR_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        por_clear |=> pre == '0 && por_done)
        else $error("power-up prescaler clear missed");

    // ****************************************
    // wait mode, cause flag and options read checks
    // ****************************************
    sequence seq_plain_count;
        i_wait_mode && wd_enabled && !stop_gate && !i_int_rst && !svc_write
        && !alarm && !i_stop_exec && !por_clear;
    endsequence

    AST_WAIT_COUNTS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        seq_plain_count |=> pre == PRE_W'($past(pre) + 1'b1))
        else $error("prescaler stalled in wait mode");

    AST_CAUSE_WINS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        fire && i_cause_clear |=> o_cause_flag)
        else $error("cause clear beat a new timeout");

    AST_OPTIONS_READ: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_rd && opt_hit |=> o_rd_data == $past(options))
        else $error("options read returned wrong data");

endmodule // wrt_watchdog
`default_nettype wire

// file: verif/tb_watchdog_reset_timer.sv
// Purpose: self-checking bench for the watchdog reset timer
// Assumes: wrt_pkg and wrt_watchdog compiled first
// Notes: expectations derive from package cycle counts
`default_nettype none
module tb_watchdog_reset_timer;
    import wrt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and device
    // ****************************************
    localparam logic [7:0] VEC = 8'h5a; // arbitrary vector byte
    logic              clk_sys;
    logic              nrst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr;
    logic              rd;
    logic              int_rst;
    logic              stop_exec;
    logic              stop_mode;
    logic              wait_mode;
    logic              mon;
    logic              tvolt;
    logic              brk;
    logic              bdis;
    logic              pin_en;
    logic              cclr;
    logic              req;
    logic              pin_out;
    logic              pin_oe;
    logic              cause;
    int                n_mismatch = 0;
    int                checks_done = 0;

    wrt_watchdog #(.VECTOR_LOW(VEC)) i_dut (
        .i_clk_sys               (clk_sys),
        .i_nrst                  (nrst),
        .i_addr                  (addr),
        .i_wr_data               (wdata),
        .i_wr                    (wr),
        .i_rd                    (rd),
        .o_rd_data               (rdata),
        .i_int_rst               (int_rst),
        .i_stop_exec             (stop_exec),
        .i_stop_mode             (stop_mode),
        .i_wait_mode             (wait_mode),
        .i_monitor_mode          (mon),
        .i_test_voltage          (tvolt),
        .i_break_active          (brk),
        .i_break_watchdog_disable(bdis),
        .i_reset_pin_enable      (pin_en),
        .i_cause_clear           (cclr),
        .o_sys_reset_req         (req),
        .o_rst_pin_out           (pin_out),
        .o_rst_pin_oe            (pin_oe),
        .o_cause_flag            (cause)
    );

    always #20 clk_sys = ~clk_sys;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic fresh(input logic [7:0] opts);
        int_rst <= 1'b1;
        @(posedge clk_sys);
        int_rst <= 1'b0;
        #1;
        bus_wr(OPTIONS_ADDR, opts);
    endtask

    task automatic quiet(input int n, input string what);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (req !== 1'b0) bad++;
        end
        check(what, bad, 0);
    endtask

    task automatic wait_req(input int done, input int lo, input int hi, input string what);
        int n;
        n = done;
        while (req !== 1'b1 && n < hi + 5) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(what, (n >= lo && n <= hi), 1);
    endtask

    task automatic pulse_len(input logic oe_exp);
        int m;
        int bad;
        m = 0;
        bad = 0;
        check("cause set", cause, 1'b1);
        while (req === 1'b1 && m < 40) begin
            if (pin_oe !== oe_exp || pin_out !== 1'b0) bad++;
            @(posedge clk_sys);
            #1;
            m++;
        end
        check("pulse length", m, PIN_LOW_CYCLES);
        check("pin drive", bad, 0);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reg();
        logic [7:0] d;
        bus_rd(OPTIONS_ADDR, d);
        check("options reset", d, OPTIONS_RESET);
        bus_rd(SERVICE_ADDR, d);
        check("vector read", d, VEC);
        bus_rd(16'h1234, d);
        check("unmapped read", d, UNMAPPED_DATA);
        bus_wr(OPTIONS_ADDR, 8'h80);
        bus_wr(OPTIONS_ADDR, 8'h01);
        bus_rd(OPTIONS_ADDR, d);
        check("options once", d, 8'h80);
        quiet(POR_CYCLES + 100, "after power up");
    endtask

    task automatic t_short();
        logic [7:0] d;
        wait_mode <= 1'b1;
        fresh(8'h80);
        bus_rd(SERVICE_ADDR, d);
        check("vector read", d, VEC);
        wait_req(2, SHORT_CYCLES, SHORT_CYCLES, "short timeout");
        pulse_len(1'b1);
        wait_mode <= 1'b0;
        cclr <= 1'b1;
        @(posedge clk_sys);
        cclr <= 1'b0;
        #1;
        check("cause clear", cause, 1'b0);
    endtask

    task automatic t_service();
        pin_en <= 1'b0;
        fresh(8'h80);
        repeat (2) begin
            quiet(6000, "serviced");
            bus_wr(SERVICE_ADDR, 8'h3c);
        end
        wait_req(0, SHORT_CYCLES - 1, SHORT_CYCLES - 1, "after service");
        pulse_len(1'b0);
        pin_en <= 1'b1;
    endtask

    task automatic t_stop_exec();
        fresh(8'h80);
        repeat (5) begin
            quiet(2000, "stop exec");
            stop_exec <= 1'b1;
            @(posedge clk_sys);
            stop_exec <= 1'b0;
            #1;
        end
    endtask

    task automatic t_disable();
        for (int i = 0; i < 3; i++) begin
            fresh((i == 0) ? 8'h81 : 8'h80);
            mon <= (i != 0);
            tvolt <= (i == 1);
            brk <= (i == 2);
            bdis <= (i == 2);
            quiet(8300, "disabled");
        end
        mon <= 1'b0;
        tvolt <= 1'b0;
        brk <= 1'b0;
        bdis <= 1'b0;
    endtask

    task automatic t_stop();
        fresh(8'h80);
        bus_wr(SERVICE_ADDR, 8'h00);
        stop_mode <= 1'b1;
        quiet(8300, "stop mode");
        stop_mode <= 1'b0;
        cclr <= 1'b1;
        wait_req(0, SHORT_CYCLES, SHORT_CYCLES, "after stop");
        pulse_len(1'b1);
        cclr <= 1'b0;
    endtask

    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        addr = '0;
        wdata = '0;
        {wr, rd, int_rst, stop_exec, stop_mode, wait_mode} = '0;
        {mon, tvolt, brk, bdis, cclr} = '0;
        pin_en = 1'b1;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reg();
        t_short();
        t_service();
        t_stop_exec();
        t_disable();
        t_stop();
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_watchdog_reset_timer
`default_nettype wire
